// File: rtl/lbr_top.sv
// remote loopback request detection, reporting and sending
`timescale 1ns/1ps
`include "lbr_defs.svh"
// Notes on behaviour
// - method 0: send bit starts/stops inversions
// - one inversion request at a time, replaced
// - group A: bit7 all-channel, bits6-0 channels
// - M13: set after five consecutive inversions
// - condition select register picks inversion condition
// - clear after five consecutive normal bits
// - FEAC: five connect, five channel words
// - FEAC: five disconnect then channel word
// - C-bit mode also detects inversions
// - many channel flags may be set together
// - inversion detection needs DS2 and DS3 sync
// - FEAC needs sync, no AIS, no idle
// - all-channel flag only in C-bit mode
// - group B bit7 DS3 request, C-bit only
// - channel n at group (n-1)%4, bit (n-1)/4
// - connect field: 1 connect, 0 disconnect
module lbr_top #(
    parameter lbr_pkg::lbr_feac_t FEAC_CONNECT = 6'h07,
    parameter lbr_pkg::lbr_feac_t FEAC_DISCONNECT = 6'h1c,
    parameter lbr_pkg::lbr_feac_t FEAC_DS3_WORD = 6'h1b,
    parameter lbr_pkg::lbr_feac_t FEAC_ALL_WORD = 6'h13,
    parameter lbr_pkg::lbr_feac_t FEAC_CHAN_BASE = 6'h20
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    input wire logic cbit_mode,
    input wire logic ds3_sync,
    input wire logic [6:0] ds2_sync,
    input wire logic ds3_ais,
    input wire logic ds3_idle,
    input wire logic rx_bit_strobe,
    input wire logic [27:0] rx_cbit_inv,
    input wire logic [27:0] rx_stuff_inv,
    input wire logic rx_feac_valid,
    input wire logic [5:0] rx_feac_code,
    output logic [27:0] tx_inv_chan,
    output logic tx_inv_cbit,
    output logic tx_inv_stuff,
    input wire logic tx_feac_ready,
    output logic tx_feac_valid,
    output logic [5:0] tx_feac_code
);
    localparam int N = `LBR_CHANNELS;

    logic [7:0] tx_cmd_ff;
    logic [7:0] feac_cfg_ff;
    logic [7:0] cond_sel_ff;
    logic [7:0] cpu_rdata_ff;
    logic [N-1:0] feac_chan_ff;
    logic feac_all_ff;
    logic feac_ds3_ff;
    lbr_pkg::lbr_rx_e rx_state_ff;
    logic [2:0] rx_cnt_ff;
    logic rx_connect_ff;
    lbr_pkg::lbr_feac_t rx_chan_word_ff;
    lbr_pkg::lbr_tx_e tx_state_ff;
    logic [3:0] tx_rep_ff;
    lbr_pkg::lbr_feac_t tx_cmd_word_ff;
    lbr_pkg::lbr_feac_t tx_chan_word_ff;
    logic tx_feac_valid_ff;
    lbr_pkg::lbr_feac_t tx_feac_code_ff;
    logic [N-1:0] tx_inv_chan_ff;
    logic tx_inv_cbit_ff;
    logic tx_inv_stuff_ff;

    logic [N-1:0] rx_cond;
    logic [N-1:0] rx_ok;
    logic [N-1:0] chan_flag;
    logic feac_ok;
    logic cmd_wr;
    logic feac_start;
    logic [4:0] cmd_chan;
    logic [N+1:0] rx_target;
    logic [N+1:0] rx_code_target;

    lbr_filt_if #(.N(N)) fi ();

    // one-hot {ds3, all, channels} selected by a received channel word
    function automatic logic [N+1:0] feac_target(input lbr_pkg::lbr_feac_t w);
        logic [N+1:0] t;
        t = '0;
        if (w == FEAC_DS3_WORD) begin
            t[N+1] = 1'b1;
        end else if (w == FEAC_ALL_WORD) begin
            t[N] = 1'b1;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (w == FEAC_CHAN_BASE + 6'(i)) begin
                    t[i] = 1'b1;
                end
            end
        end
        return t;
    endfunction

    function automatic logic is_feac_cmd(input lbr_pkg::lbr_feac_t w);
        return (w == FEAC_CONNECT) || (w == FEAC_DISCONNECT);
    endfunction

    // one group register: channel n lands at group (n-1)%4, bit (n-1)/4
    function automatic logic [6:0] group_bits(input logic [N-1:0] v, input int k);
        logic [6:0] r;
        r = '0;
        for (int b = 0; b < 7; b++) begin
            r[b] = v[4*b+k];
        end
        return r;
    endfunction

    assign cmd_wr = ce && cpu_wr && (cpu_addr == `LBR_ADDR_TX_CMD);
    assign cmd_chan = tx_cmd_ff[`LBR_CMD_CHAN_MSB:0];
    assign feac_ok = cbit_mode && ds3_sync && !ds3_ais && !ds3_idle;
    assign feac_start = cmd_wr && cpu_wdata[`LBR_CMD_METHOD_BIT]
        && cpu_wdata[`LBR_CMD_SEND_BIT] && cbit_mode
        && feac_cfg_ff[`LBR_FEAC_CLK_SEL_BIT];
    assign rx_target = feac_target(rx_chan_word_ff);
    assign rx_code_target = feac_target(rx_feac_code);

    // inversion condition per channel, chosen by the select register
    always_comb begin
        rx_cond = '0;
        rx_ok = '0;
        for (int i = 0; i < N; i++) begin
            rx_cond[i] = (cond_sel_ff[`LBR_SEL_RX_CBIT_BIT] || cond_sel_ff[`LBR_SEL_RX_STUFF_BIT])
                && (!cond_sel_ff[`LBR_SEL_RX_CBIT_BIT] || rx_cbit_inv[i])
                && (!cond_sel_ff[`LBR_SEL_RX_STUFF_BIT] || rx_stuff_inv[i]);
            rx_ok[i] = ds3_sync && ds2_sync[i/4];
        end
    end

    // inversions counted in both framing modes
    assign fi.ce = ce;
    assign fi.sample = rx_bit_strobe;
    assign fi.cond = rx_cond;
    assign fi.ok = rx_ok;
    assign chan_flag = fi.flag | (cbit_mode ? feac_chan_ff : '0);

    lbr_persist #(.N(N)) u_persist (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .fi(fi)
    );

    // software-visible configuration; loopbacks are applied by software
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_cmd_ff <= `LBR_TX_CMD_RESET;
            feac_cfg_ff <= `LBR_FEAC_CFG_RESET;
            cond_sel_ff <= `LBR_COND_SEL_RESET;
        end else if (ce && cpu_wr) begin
            case (cpu_addr)
                `LBR_ADDR_TX_CMD: tx_cmd_ff <= cpu_wdata;
                `LBR_ADDR_FEAC_CFG: feac_cfg_ff <= cpu_wdata;
                `LBR_ADDR_COND_SEL: cond_sel_ff <= cpu_wdata;
                default: tx_cmd_ff <= tx_cmd_ff;
            endcase
        end
    end

    // register reads, answered on the edge after cpu_rd
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_rdata_ff <= 8'h00;
        end else if (ce && cpu_rd) begin
            case (cpu_addr)
                `LBR_ADDR_TX_CMD: cpu_rdata_ff <= tx_cmd_ff;
                `LBR_ADDR_FEAC_CFG: cpu_rdata_ff <= feac_cfg_ff;
                `LBR_ADDR_COND_SEL: cpu_rdata_ff <= cond_sel_ff;
                `LBR_ADDR_RX_GRP_A:
                    cpu_rdata_ff <= {cbit_mode && feac_all_ff, group_bits(chan_flag, 0)};
                `LBR_ADDR_RX_GRP_B:
                    cpu_rdata_ff <= {cbit_mode && feac_ds3_ff, group_bits(chan_flag, 1)};
                `LBR_ADDR_RX_GRP_C: cpu_rdata_ff <= {1'b0, group_bits(chan_flag, 2)};
                `LBR_ADDR_RX_GRP_D: cpu_rdata_ff <= {1'b0, group_bits(chan_flag, 3)};
                default: cpu_rdata_ff <= 8'h00;
            endcase
        end
    end

    // FEAC receive: command word five times, then the channel word
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state_ff <= lbr_pkg::LBR_RX_IDLE;
            rx_cnt_ff <= 3'h0;
            rx_connect_ff <= 1'b0;
            rx_chan_word_ff <= 6'h00;
            feac_chan_ff <= '0;
            feac_all_ff <= 1'b0;
            feac_ds3_ff <= 1'b0;
        end else if (ce) begin
            if (!feac_ok) begin
                rx_state_ff <= lbr_pkg::LBR_RX_IDLE;
            end else if (rx_feac_valid) begin
                case (rx_state_ff)
                    lbr_pkg::LBR_RX_IDLE: begin
                        if (is_feac_cmd(rx_feac_code)) begin
                            rx_connect_ff <= (rx_feac_code == FEAC_CONNECT);
                            rx_cnt_ff <= 3'h1;
                            rx_state_ff <= lbr_pkg::LBR_RX_CMD;
                        end
                    end
                    lbr_pkg::LBR_RX_CMD: begin
                        if (rx_feac_code == (rx_connect_ff ? FEAC_CONNECT : FEAC_DISCONNECT)) begin
                            if (rx_cnt_ff < `LBR_PERSIST) begin
                                rx_cnt_ff <= rx_cnt_ff + 3'h1;
                            end
                        end else if (rx_cnt_ff >= `LBR_PERSIST
                                     && rx_code_target != '0) begin
                            rx_chan_word_ff <= rx_feac_code;
                            rx_cnt_ff <= 3'h1;
                            if (rx_connect_ff) begin
                                rx_state_ff <= lbr_pkg::LBR_RX_CHAN;
                            end else begin
                                // one channel word is enough to clear
                                feac_chan_ff <= feac_chan_ff & ~rx_code_target[N-1:0];
                                feac_all_ff <= feac_all_ff && !rx_code_target[N];
                                feac_ds3_ff <= feac_ds3_ff && !rx_code_target[N+1];
                                rx_state_ff <= lbr_pkg::LBR_RX_IDLE;
                            end
                        end else if (is_feac_cmd(rx_feac_code)) begin
                            rx_connect_ff <= (rx_feac_code == FEAC_CONNECT);
                            rx_cnt_ff <= 3'h1;
                        end else begin
                            rx_state_ff <= lbr_pkg::LBR_RX_IDLE;
                        end
                    end
                    lbr_pkg::LBR_RX_CHAN: begin
                        if (rx_feac_code == rx_chan_word_ff) begin
                            rx_cnt_ff <= rx_cnt_ff + 3'h1;
                            if (rx_cnt_ff + 3'h1 >= `LBR_PERSIST) begin
                                feac_chan_ff <= feac_chan_ff | rx_target[N-1:0];
                                feac_all_ff <= feac_all_ff || rx_target[N];
                                feac_ds3_ff <= feac_ds3_ff || rx_target[N+1];
                                rx_state_ff <= lbr_pkg::LBR_RX_IDLE;
                            end
                        end else begin
                            rx_state_ff <= lbr_pkg::LBR_RX_IDLE;
                        end
                    end
                    default: rx_state_ff <= lbr_pkg::LBR_RX_IDLE;
                endcase
            end
        end
    end

    // inversion send: a single channel, the latest command replaces the last
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_inv_chan_ff <= '0;
            tx_inv_cbit_ff <= 1'b0;
            tx_inv_stuff_ff <= 1'b0;
        end else if (ce) begin
            tx_inv_chan_ff <= '0;
            tx_inv_cbit_ff <= 1'b0;
            tx_inv_stuff_ff <= 1'b0;
            // connect field ignored for this method
            if (!tx_cmd_ff[`LBR_CMD_METHOD_BIT] && tx_cmd_ff[`LBR_CMD_SEND_BIT]) begin
                for (int i = 0; i < N; i++) begin
                    tx_inv_chan_ff[i] <= (cmd_chan == 5'(i + 1));
                end
                tx_inv_cbit_ff <= cond_sel_ff[`LBR_SEL_TX_CBIT_BIT];
                tx_inv_stuff_ff <= cond_sel_ff[`LBR_SEL_TX_STUFF_BIT];
            end
        end
    end

    // FEAC send: command word, then channel word, each repeated
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_state_ff <= lbr_pkg::LBR_TX_IDLE;
            tx_rep_ff <= 4'h0;
            tx_cmd_word_ff <= 6'h00;
            tx_chan_word_ff <= 6'h00;
            tx_feac_valid_ff <= 1'b0;
            tx_feac_code_ff <= 6'h00;
        end else if (ce) begin
            if (feac_start) begin
                // connect field: 1 connect, 0 disconnect
                tx_cmd_word_ff <= cpu_wdata[`LBR_CMD_CONNECT_BIT] ? FEAC_CONNECT
                    : FEAC_DISCONNECT;
                tx_feac_code_ff <= cpu_wdata[`LBR_CMD_CONNECT_BIT] ? FEAC_CONNECT
                    : FEAC_DISCONNECT;
                if (cpu_wdata[`LBR_CMD_CHAN_MSB:0] == `LBR_CHAN_CODE_ALL) begin
                    tx_chan_word_ff <= FEAC_ALL_WORD;
                end else if (cpu_wdata[`LBR_CMD_CHAN_MSB:0] == `LBR_CHAN_CODE_DS3) begin
                    tx_chan_word_ff <= FEAC_DS3_WORD;
                end else begin
                    tx_chan_word_ff <= FEAC_CHAN_BASE + 6'(cpu_wdata[`LBR_CMD_CHAN_MSB:0]) - 6'h01;
                end
                tx_rep_ff <= 4'h0;
                tx_feac_valid_ff <= 1'b1;
                tx_state_ff <= lbr_pkg::LBR_TX_CMD;
            end else if (tx_feac_valid_ff && tx_feac_ready) begin
                case (tx_state_ff)
                    lbr_pkg::LBR_TX_CMD: begin
                        if (tx_rep_ff + 4'h1 >= `LBR_TX_REPEAT) begin
                            tx_rep_ff <= 4'h0;
                            tx_feac_code_ff <= tx_chan_word_ff;
                            tx_state_ff <= lbr_pkg::LBR_TX_CHAN;
                        end else begin
                            tx_rep_ff <= tx_rep_ff + 4'h1;
                        end
                    end
                    lbr_pkg::LBR_TX_CHAN: begin
                        if (tx_rep_ff + 4'h1 >= `LBR_TX_REPEAT) begin
                            tx_rep_ff <= 4'h0;
                            tx_feac_valid_ff <= 1'b0;
                            tx_state_ff <= lbr_pkg::LBR_TX_IDLE;
                        end else begin
                            tx_rep_ff <= tx_rep_ff + 4'h1;
                        end
                    end
                    default: begin
                        tx_feac_valid_ff <= 1'b0;
                        tx_state_ff <= lbr_pkg::LBR_TX_IDLE;
                    end
                endcase
            end
        end
    end

    assign cpu_rdata = cpu_rdata_ff;
    assign tx_inv_chan = tx_inv_chan_ff;
    assign tx_inv_cbit = tx_inv_cbit_ff;
    assign tx_inv_stuff = tx_inv_stuff_ff;
    assign tx_feac_valid = tx_feac_valid_ff;
    assign tx_feac_code = tx_feac_code_ff;
endmodule

// File: rtl/lbr_defs.svh
// register offsets, field positions, reset values and counts for loopback requests
`ifndef LBR_DEFS_SVH
`define LBR_DEFS_SVH

`define LBR_ADDR_TX_CMD 8'h07
`define LBR_ADDR_RX_GRP_A 8'h08
`define LBR_ADDR_RX_GRP_B 8'h09
`define LBR_ADDR_RX_GRP_C 8'h0a
`define LBR_ADDR_RX_GRP_D 8'h0b
`define LBR_ADDR_FEAC_CFG 8'h19
`define LBR_ADDR_COND_SEL 8'h20

`define LBR_CMD_SEND_BIT 7
`define LBR_CMD_CONNECT_BIT 6
`define LBR_CMD_METHOD_BIT 5
`define LBR_CMD_CHAN_MSB 4
`define LBR_FEAC_CLK_SEL_BIT 0
`define LBR_SEL_RX_CBIT_BIT 0
`define LBR_SEL_RX_STUFF_BIT 1
`define LBR_SEL_TX_CBIT_BIT 2
`define LBR_SEL_TX_STUFF_BIT 3

`define LBR_TX_CMD_RESET 8'h00
`define LBR_FEAC_CFG_RESET 8'h00
`define LBR_COND_SEL_RESET 8'h00

`define LBR_CHAN_CODE_ALL 5'h00
`define LBR_CHAN_CODE_DS3 5'h1d
`define LBR_CHANNELS 28

`define LBR_PERSIST 3'h5
`define LBR_TX_REPEAT 4'ha

`endif

// File: rtl/lbr_pkg.sv
// shared types for the loopback request block
package lbr_pkg;
    typedef enum logic [1:0] {
        LBR_RX_IDLE,
        LBR_RX_CMD,
        LBR_RX_CHAN
    } lbr_rx_e;

    typedef enum logic [1:0] {
        LBR_TX_IDLE,
        LBR_TX_CMD,
        LBR_TX_CHAN
    } lbr_tx_e;

    typedef logic [5:0] lbr_feac_t;
endpackage

// File: rtl/lbr_filt_if.sv
// carrier between the request block and its persistence filter
`timescale 1ns/1ps
interface lbr_filt_if #(parameter int N = 28);
    logic ce;
    logic sample;
    logic [N-1:0] cond;
    logic [N-1:0] ok;
    logic [N-1:0] flag;

    modport ctl (output ce, output sample, output cond, output ok, input flag);
    modport filt (input ce, input sample, input cond, input ok, output flag);
endinterface

// File: rtl/lbr_persist.sv
// per-channel persistence filter: a flag flips after five equal opposite samples
`timescale 1ns/1ps
`include "lbr_defs.svh"
module lbr_persist #(parameter int N = 28) (
    input wire logic ref_clk,
    input wire logic rst_b,
    lbr_filt_if.filt fi
);
    logic [2:0] cnt_ff [N];
    logic [N-1:0] flag_ff;

    assign fi.flag = flag_ff;

    // each channel counts on its own, so many flags may stand at once
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_ff <= '0;
            for (int i = 0; i < N; i++) begin
                cnt_ff[i] <= 3'h0;
            end
        end else if (fi.ce && fi.sample) begin
            for (int i = 0; i < N; i++) begin
                if (fi.ok[i]) begin
                    if (fi.cond[i] == flag_ff[i]) begin
                        cnt_ff[i] <= 3'h0;
                    end else if (cnt_ff[i] + 3'h1 >= `LBR_PERSIST) begin
                        // set after five inversions, clear after five normal
                        flag_ff[i] <= fi.cond[i];
                        cnt_ff[i] <= 3'h0;
                    end else begin
                        cnt_ff[i] <= cnt_ff[i] + 3'h1;
                    end
                end
            end
        end
    end
endmodule

// File: testbench/lbr_top_monitor.sv
// concurrent checks on the loopback request block ports
`timescale 1ns/1ps
module lbr_monitor (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_rdata,
    input wire logic cbit_mode,
    input wire logic [27:0] tx_inv_chan,
    input wire logic tx_feac_ready,
    input wire logic tx_feac_valid,
    input wire logic [5:0] tx_feac_code
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic wr7;
    logic rd_ok;
    assign wr7 = ce && cpu_wr && cpu_addr == 8'h07;
    assign rd_ok = ce && cpu_rd;

    chk_tx_single_chan: assert property ($onehot0(tx_inv_chan))
        else $error("more than one channel inverted");
    chk_tx_send_on: assert property (wr7 && cpu_wdata[7] && !cpu_wdata[5]
        && cpu_wdata[4:0] inside {[5'h01:5'h1c]}
        |-> ##2 tx_inv_chan == (28'h1 << ($past(cpu_wdata[4:0], 2) - 5'h01)))
        else $error("inverted channel does not follow command");
    chk_tx_send_off: assert property (wr7 && !cpu_wdata[7] |-> ##2 tx_inv_chan == 28'h0)
        else $error("inversion kept after stop");
    chk_rd_unmapped_zero: assert property (rd_ok
        && !(cpu_addr inside {8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h19, 8'h20})
        |=> cpu_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rd_top_zero: assert property (rd_ok && cpu_addr inside {8'h0a, 8'h0b}
        |=> !cpu_rdata[7])
        else $error("unused status bit set");
    chk_all_m13_off: assert property (rd_ok && cpu_addr == 8'h08 && !cbit_mode
        |=> !cpu_rdata[7])
        else $error("all channel flag outside parity mode");
    chk_ds3_m13_off: assert property (rd_ok && cpu_addr == 8'h09 && !cbit_mode
        |=> !cpu_rdata[7])
        else $error("high rate flag outside parity mode");
    chk_rd_data_hold: assert property (!rd_ok |=> $stable(cpu_rdata))
        else $error("read data moved without read");
    chk_feac_word_hold: assert property (tx_feac_valid && !tx_feac_ready && ce
        && !wr7 && !$past(wr7) |=> tx_feac_valid && $stable(tx_feac_code))
        else $error("feac word dropped before accept");
    chk_feac_mode_refuse: assert property (wr7 && cpu_wdata[5] && cpu_wdata[7]
        && !cbit_mode && !tx_feac_valid |=> !tx_feac_valid)
        else $error("feac started outside parity mode");

    cov_tx_inv: cover property (tx_inv_chan != 28'h0);
    cov_feac_stall: cover property (tx_feac_valid && !tx_feac_ready);
    cov_all_flag: cover property (rd_ok && cpu_addr == 8'h08 ##1 cpu_rdata[7]);
endmodule

bind lbr_top lbr_monitor u_lbr_monitor (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .cbit_mode(cbit_mode), .tx_inv_chan(tx_inv_chan),
    .tx_feac_ready(tx_feac_ready), .tx_feac_valid(tx_feac_valid),
    .tx_feac_code(tx_feac_code));

// File: testbench/lbr_far_end.sv
// distant-end multiplexer: sends requests, accepts feac words
`timescale 1ns/1ps
module lbr_far_end (
    input wire logic ref_clk,
    input wire logic slow,
    output logic rx_bit_strobe,
    output logic [27:0] rx_cbit_inv,
    output logic [27:0] rx_stuff_inv,
    output logic rx_feac_valid,
    output logic [5:0] rx_feac_code,
    input wire logic tx_feac_valid,
    input wire logic [5:0] tx_feac_code,
    output logic tx_feac_ready
);
    logic [5:0] got[$];
    logic [1:0] tick;
    initial begin
        {rx_bit_strobe, rx_feac_valid, tx_feac_ready, tick} = '0;
        rx_cbit_inv = '0;
        rx_stuff_inv = '0;
        rx_feac_code = '0;
    end
    // stalls three cycles of four when slow
    always @(posedge ref_clk) begin
        tick <= tick + 2'h1;
        tx_feac_ready <= !slow || tick == 2'h0;
        if (tx_feac_valid && tx_feac_ready) begin
            got.push_back(tx_feac_code);
        end
    end
    task automatic inv(input logic [27:0] c, input logic [27:0] s, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            rx_bit_strobe <= 1'b1;
            rx_cbit_inv <= c;
            rx_stuff_inv <= s;
        end
        @(posedge ref_clk);
        rx_bit_strobe <= 1'b0;
        rx_cbit_inv <= ~c;
        rx_stuff_inv <= ~s;
    endtask
    task automatic feac(input logic [5:0] a, input int na, input logic [5:0] b, input int nb);
        for (int i = 0; i < na + nb; i++) begin
            @(posedge ref_clk);
            rx_feac_valid <= 1'b1;
            rx_feac_code <= (i < na) ? a : b;
        end
        @(posedge ref_clk);
        rx_feac_valid <= 1'b0;
        rx_feac_code <= ~rx_feac_code;
    endtask
endmodule

// File: testbench/lbr_top_test.sv
// self-checking bench for the loopback request block
`timescale 1ns/1ps
module lbr_top_test;
    localparam logic [5:0] F_CON = 6'h07;
    localparam logic [5:0] F_DIS = 6'h1c;
    localparam logic [5:0] F_DS3 = 6'h1b;
    localparam logic [5:0] F_ALL = 6'h13;
    localparam logic [5:0] F_BASE = 6'h20;
    logic ref_clk, rst_b, ce, cpu_wr, cpu_rd, cbit_mode, ds3_sync, ds3_ais, ds3_idle, slow;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata;
    logic [6:0] ds2_sync;
    logic rx_bit_strobe, rx_feac_valid, tx_feac_ready, tx_inv_cbit, tx_inv_stuff, tx_feac_valid;
    logic [27:0] rx_cbit_inv, rx_stuff_inv, tx_inv_chan;
    logic [5:0] rx_feac_code, tx_feac_code;
    logic [7:0] regs [10] = '{8'h07, 8'h19, 8'h20, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h30, 8'h1e, 8'hff};
    int bad_count, n_tests;

    lbr_top #(.FEAC_CONNECT(F_CON), .FEAC_DISCONNECT(F_DIS), .FEAC_DS3_WORD(F_DS3),
        .FEAC_ALL_WORD(F_ALL), .FEAC_CHAN_BASE(F_BASE)) u_lbr_top (.ref_clk(ref_clk),
        .rst_b(rst_b), .ce(ce), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cbit_mode(cbit_mode), .ds3_sync(ds3_sync),
        .ds2_sync(ds2_sync), .ds3_ais(ds3_ais), .ds3_idle(ds3_idle),
        .rx_bit_strobe(rx_bit_strobe), .rx_cbit_inv(rx_cbit_inv), .rx_stuff_inv(rx_stuff_inv),
        .rx_feac_valid(rx_feac_valid), .rx_feac_code(rx_feac_code), .tx_inv_chan(tx_inv_chan),
        .tx_inv_cbit(tx_inv_cbit), .tx_inv_stuff(tx_inv_stuff), .tx_feac_ready(tx_feac_ready),
        .tx_feac_valid(tx_feac_valid), .tx_feac_code(tx_feac_code));
    lbr_far_end u_lbr_far_end (.ref_clk(ref_clk), .slow(slow), .rx_bit_strobe(rx_bit_strobe),
        .rx_cbit_inv(rx_cbit_inv), .rx_stuff_inv(rx_stuff_inv), .rx_feac_valid(rx_feac_valid),
        .rx_feac_code(rx_feac_code), .tx_feac_valid(tx_feac_valid),
        .tx_feac_code(tx_feac_code), .tx_feac_ready(tx_feac_ready));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        cpu_wr <= 1'b1;
        cpu_addr <= a;
        cpu_wdata <= v;
        @(posedge ref_clk);
        cpu_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        cpu_rd <= 1'b1;
        cpu_addr <= a;
        @(posedge ref_clk);
        cpu_rd <= 1'b0;
        #1 check(cpu_rdata, exp);
    endtask
    task automatic t_regs();
        @(posedge ref_clk);
        ce <= 1'b0;
        wr(8'h20, 8'hff);
        @(posedge ref_clk);
        ce <= 1'b1;
        wr(8'h08, 8'hff);
        foreach (regs[i]) rd(regs[i], 8'h00);
    endtask
    task automatic t_inv_rx();
        wr(8'h20, 8'h01);
        u_lbr_far_end.inv(28'h800_0020, 28'h0, 4);
        rd(8'h09, 8'h00);
        u_lbr_far_end.inv(28'h800_0020, 28'h0, 1);
        rd(8'h09, 8'h02);
        rd(8'h0b, 8'h40);
        @(posedge ref_clk);
        ds2_sync <= 7'h7d;
        u_lbr_far_end.inv(28'h0, 28'h0, 5);
        rd(8'h09, 8'h02);
        rd(8'h0b, 8'h00);
        ds2_sync <= 7'h7f;
        u_lbr_far_end.inv(28'h0, 28'h1, 5);
        rd(8'h08, 8'h00);
        wr(8'h20, 8'h03);
        u_lbr_far_end.inv(28'h1, 28'h0, 5);
        rd(8'h08, 8'h00);
        u_lbr_far_end.inv(28'h1, 28'h1, 5);
        rd(8'h08, 8'h01);
        u_lbr_far_end.inv(28'h0, 28'h0, 5);
        rd(8'h08, 8'h00);
    endtask
    task automatic t_feac_rx();
        cbit_mode <= 1'b1;
        u_lbr_far_end.feac(F_CON, 5, F_BASE + 6'h02, 5);
        rd(8'h0a, 8'h01);
        check(tx_feac_valid, 1'b0);
        u_lbr_far_end.feac(F_CON, 5, F_ALL, 5);
        rd(8'h08, 8'h80);
        u_lbr_far_end.feac(F_CON, 5, F_DS3, 5);
        wr(8'h20, 8'h01);
        u_lbr_far_end.inv(28'h2, 28'h0, 5);
        rd(8'h09, 8'h81);
        cbit_mode <= 1'b0;
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h01);
        cbit_mode <= 1'b1;
        u_lbr_far_end.feac(F_DIS, 5, F_BASE + 6'h02, 1);
        rd(8'h0a, 8'h00);
        ds3_ais <= 1'b1;
        u_lbr_far_end.feac(F_CON, 5, F_BASE + 6'h02, 5);
        rd(8'h0a, 8'h00);
        ds3_ais <= 1'b0;
        ds3_idle <= 1'b1;
        u_lbr_far_end.feac(F_CON, 5, F_BASE + 6'h02, 5);
        rd(8'h0a, 8'h00);
        ds3_idle <= 1'b0;
        u_lbr_far_end.inv(28'h0, 28'h0, 5);
    endtask
    task automatic t_inv_tx();
        wr(8'h20, 8'h04);
        wr(8'h07, 8'h85);
        @(posedge ref_clk);
        #1 check(tx_inv_chan, 28'h10);
        check({tx_inv_cbit, tx_inv_stuff}, 2'b10);
        wr(8'h07, 8'hc9);
        @(posedge ref_clk);
        #1 check(tx_inv_chan, 28'h100);
        wr(8'h07, 8'h09);
        @(posedge ref_clk);
        #1 check(tx_inv_chan, 28'h0);
    endtask
    task automatic t_feac_tx();
        int k;
        slow <= 1'b1;
        cbit_mode <= 1'b0;
        wr(8'h19, 8'h01);
        wr(8'h07, 8'he7);
        repeat (3) @(posedge ref_clk);
        #1 check(tx_feac_valid, 1'b0);
        cbit_mode <= 1'b1;
        wr(8'h07, 8'he7);
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while ((tx_feac_valid !== 1'b0 || k < 3) && k < 400);
        check(u_lbr_far_end.got.size(), 20);
        foreach (u_lbr_far_end.got[i]) check(u_lbr_far_end.got[i], i < 10 ? F_CON : F_BASE + 6'h06);
        slow <= 1'b0;
        wr(8'h07, 8'hbd);
        repeat (30) @(posedge ref_clk);
        #1 check(tx_feac_valid, 1'b0);
        check(u_lbr_far_end.got.size(), 40);
        check(u_lbr_far_end.got[20], F_DIS);
        check(u_lbr_far_end.got[39], F_DS3);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #60000;
        bad_count++;
        wrap_up();
    end
    initial begin
        {rst_b, ce, cpu_wr, cpu_rd, cbit_mode, ds3_ais, ds3_idle, slow} = '0;
        ds3_sync = 1'b1;
        ds2_sync = 7'h7f;
        cpu_addr = '0;
        cpu_wdata = '0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        ce <= 1'b1;
        t_regs();
        $display("register test done");
        t_inv_rx();
        $display("inversion receive test done");
        t_feac_rx();
        $display("feac receive test done");
        t_inv_tx();
        $display("inversion send test done");
        t_feac_tx();
        $display("feac send test done");
        wrap_up();
    end
endmodule
